// ==== verilog/tpl_loader.sv ====
`include "tpl_defs.svh"
module tpl_loader import tpl_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_int_n,
  output logic o_sensing_mode,
  output logic o_profile_valid,
  output logic o_busy
);
  // Command types that only take effect after the unlock
  function automatic logic tpl_guarded(input logic [3:0] c);
    return (c == `TPL_CMD_ERASE) || (c == `TPL_CMD_WRITE) || (c == `TPL_CMD_CRC);
  endfunction

  tpl_bus_t bus_st;
  tpl_eng_t eng_st;
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic ack_slot;
  logic [7:0] shreg;
  logic rd_mode;
  logic master_ack;
  logic [3:0] byte_idx;
  logic [3:0] cmd;
  logic pkt_ok;
  logic unlocked;
  logic sensing;
  logic valid;
  logic [15:0] stored_crc;
  logic [7:0] crc_hi;
  logic [7:0] crc_lo;
  logic [8:0] wptr;
  logic [8:0] eng_addr;
  logic sda_oe;
  logic [7:0] mem [0:511];

  tpl_crc_if crc_bus ();

  tpl_crc_unit u_crc (
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .crc_port(crc_bus)
  );

  // Bus conditions from the previous sample of both lines
  wire logic scl_rise = i_scl & ~scl_q;
  wire logic scl_fall = ~i_scl & scl_q;
  wire logic start_c = i_scl & scl_q & sda_q & ~i_sda;
  wire logic stop_c = i_scl & scl_q & ~sda_q & i_sda;
  wire logic selected = ~i_int_n & ~sensing;
  wire logic busy = (eng_st != ENG_IDLE);
  wire logic addr_match = (shreg[7:1] == `TPL_SLAVE_ADDR7);
  wire logic [7:0] status_byte = valid ? `TPL_STAT_VALID : `TPL_STAT_INVALID;
  wire logic [2:0] tx_idx = 3'h7 - bit_cnt[2:0];
  wire logic tx_bit = status_byte[tx_idx];

  // Byte boundaries: end of 8 data bits, and end of the ninth (ack) clock
  wire logic byte_end = scl_fall & ~ack_slot & (bit_cnt == `TPL_BITS_PER_BYTE);
  wire logic ack_end = scl_fall & ack_slot;
  wire logic first_byte = (byte_idx == 4'h0);
  // Busy engine refuses the command byte, so the host resends the packet
  wire logic cmd_accept = ~busy;

  // Profile data lands straight in the array in ascending order
  wire logic in_payload = (byte_idx != 4'h0) && (byte_idx < `TPL_WRITE_LEN);
  wire logic [8:0] data_wa = wptr + {5'h00, byte_idx} - 9'h001;
  wire logic data_we = byte_end && (bus_st == BUS_RX) && pkt_ok && unlocked
                       && (cmd == `TPL_CMD_WRITE) && in_payload
                       && (data_wa <= `TPL_PROFILE_LAST);
  wire logic erase_we = (eng_st == ENG_ERASE);
  wire logic mem_we = erase_we | data_we;
  wire logic [8:0] mem_wa = erase_we ? eng_addr : data_wa;
  wire logic [7:0] mem_wd = erase_we ? `TPL_ERASED_BYTE : shreg;

  // Commands run at the stop, so a cut-short packet changes no state; write bytes already stored stay in the array
  wire logic rx_done = stop_c && (bus_st == BUS_RX) && pkt_ok;
  wire logic do_unlock = rx_done && (cmd == `TPL_CMD_UNLOCK);
  wire logic do_erase = rx_done && unlocked && (cmd == `TPL_CMD_ERASE);
  wire logic do_write = rx_done && unlocked && (cmd == `TPL_CMD_WRITE)
                        && (byte_idx == `TPL_WRITE_LEN);
  wire logic do_crc = rx_done && unlocked && (cmd == `TPL_CMD_CRC)
                      && (byte_idx == `TPL_CRC_LEN);
  wire logic do_mode = rx_done && (cmd == `TPL_CMD_MODE) && valid && ~busy;
  wire logic eng_last = (eng_addr == `TPL_PROFILE_LAST);
  wire logic scan_go = do_write | do_crc | (erase_we & eng_last);

  assign crc_bus.clear = scan_go;
  assign crc_bus.feed = (eng_st == ENG_SCAN);
  assign crc_bus.data_byte = mem[eng_addr];

  // Array has no reset: the engine wipes it after reset instead
  always_ff @(posedge i_sys_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Line history for edge and start/stop detection
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= i_scl;
      sda_q <= i_sda;
    end
  end

  // Serial slave; SDA only changes on SCL falling edges
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      bus_st <= BUS_IDLE;
      bit_cnt <= 4'h0;
      ack_slot <= 1'b0;
      shreg <= 8'h00;
      rd_mode <= 1'b0;
      master_ack <= 1'b0;
      byte_idx <= 4'h0;
      cmd <= 4'h0;
      pkt_ok <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_c) begin
      bus_st <= sensing ? BUS_IDLE : BUS_ADDR;
      bit_cnt <= 4'h0;
      ack_slot <= 1'b0;
      byte_idx <= 4'h0;
      pkt_ok <= 1'b0;
      sda_oe <= 1'b0;
    end else if (stop_c) begin
      bus_st <= BUS_IDLE;
      ack_slot <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_st != BUS_IDLE) begin
      if (scl_rise && ack_slot && bus_st == BUS_TX) begin
        master_ack <= ~i_sda;
      end else if (scl_rise && ~ack_slot && bit_cnt < `TPL_BITS_PER_BYTE) begin
        shreg <= {shreg[6:0], i_sda};
        bit_cnt <= bit_cnt + 4'h1;
      end else if (byte_end) begin
        ack_slot <= 1'b1;
        unique case (bus_st)
          BUS_ADDR: begin
            if (addr_match && selected) begin
              sda_oe <= 1'b1;
              rd_mode <= shreg[0];
            end else begin
              bus_st <= BUS_IDLE;
            end
          end
          BUS_RX: begin
            if (first_byte) begin
              cmd <= shreg[3:0];
              pkt_ok <= cmd_accept;
              sda_oe <= cmd_accept;
              if (!cmd_accept) begin
                bus_st <= BUS_IDLE;
              end
            end else begin
              sda_oe <= 1'b1;
            end
            if (byte_idx != 4'hf) begin
              byte_idx <= byte_idx + 4'h1;
            end
          end
          BUS_TX: sda_oe <= 1'b0; // Release for the master's ack
          default: bus_st <= BUS_IDLE;
        endcase
      end else if (ack_end) begin
        ack_slot <= 1'b0;
        bit_cnt <= 4'h0;
        if (bus_st == BUS_ADDR && rd_mode) begin
          bus_st <= BUS_TX;
          sda_oe <= ~status_byte[7];
        end else if (bus_st == BUS_ADDR) begin
          bus_st <= BUS_RX;
          sda_oe <= 1'b0;
        end else if (bus_st == BUS_TX && master_ack) begin
          sda_oe <= ~status_byte[7]; // Repeat the status while acked
        end else begin
          if (bus_st == BUS_TX) begin
            bus_st <= BUS_IDLE;
          end
          sda_oe <= 1'b0;
        end
      end else if (scl_fall && bus_st == BUS_TX && bit_cnt != 4'h0) begin
        sda_oe <= ~tx_bit;
      end
    end
  end

  // Capture the CRC bytes, high byte first
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      crc_hi <= 8'h00;
      crc_lo <= 8'h00;
    end else if (byte_end && bus_st == BUS_RX && pkt_ok && cmd == `TPL_CMD_CRC) begin
      if (byte_idx == 4'h1) begin
        crc_hi <= shreg;
      end else if (byte_idx == 4'h2) begin
        crc_lo <= shreg;
      end
    end
  end

  // Loader state; sensing is sticky until reset
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      unlocked <= 1'b0;
      sensing <= 1'b0;
      stored_crc <= `TPL_CRC_RESET;
      wptr <= 9'h000;
    end else begin
      if (do_unlock) begin
        unlocked <= 1'b1;
      end
      if (do_mode) begin
        sensing <= 1'b1;
      end
      if (do_crc) begin
        stored_crc <= {crc_hi, crc_lo};
      end
      if (do_erase) begin
        wptr <= 9'h000;
      end else if (do_write) begin
        wptr <= wptr + `TPL_PKT_STEP;
      end
    end
  end

  // Engine: wipe, then CRC over the whole profile, then compare.
  // Reset runs the wipe so the stored image starts defined, at the cost of
  // losing the profile across reset.
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      eng_st <= ENG_ERASE;
      eng_addr <= 9'h000;
      valid <= 1'b0;
    end else begin
      unique case (eng_st)
        ENG_IDLE: begin
          if (do_erase) begin
            eng_st <= ENG_ERASE;
            eng_addr <= 9'h000;
            valid <= 1'b0;
          end else if (scan_go) begin
            eng_st <= ENG_SCAN;
            eng_addr <= 9'h000;
            valid <= 1'b0;
          end
        end
        ENG_ERASE: begin
          eng_addr <= eng_last ? 9'h000 : eng_addr + 9'h001;
          if (eng_last) begin
            eng_st <= ENG_SCAN;
          end
        end
        ENG_SCAN: begin
          eng_addr <= eng_addr + 9'h001;
          if (eng_last) begin
            eng_st <= ENG_CHECK;
          end
        end
        ENG_CHECK: begin
          valid <= (crc_bus.crc == stored_crc);
          eng_st <= ENG_IDLE;
        end
      endcase
    end
  end

  // Registered outputs; data line is open drain and only ever pulled low
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_sda <= 1'b0;
      o_sda_oe <= 1'b0;
      o_sensing_mode <= 1'b0;
      o_profile_valid <= 1'b0;
      o_busy <= 1'b1;
    end else begin
      o_sda <= 1'b0;
      o_sda_oe <= sda_oe;
      o_sensing_mode <= sensing;
      o_profile_valid <= valid;
      o_busy <= busy;
    end
  end
endmodule // tpl_loader

// ==== shared/tpl_defs.svh ====
`ifndef TPL_DEFS_SVH
`define TPL_DEFS_SVH
`define TPL_SLAVE_ADDR7 7'h60
`define TPL_CMD_MODE 4'h8
`define TPL_CMD_UNLOCK 4'h9
`define TPL_CMD_ERASE 4'ha
`define TPL_CMD_WRITE 4'hb
`define TPL_CMD_CRC 4'hc
`define TPL_STAT_VALID 8'h80
`define TPL_STAT_INVALID 8'h01
`define TPL_PROFILE_LAST 9'h1fd
`define TPL_ERASED_BYTE 8'hff
`define TPL_CRC_POLY 16'h1021
`define TPL_CRC_SEED 16'hffff
`define TPL_CRC_RESET 16'h0000
`define TPL_BITS_PER_BYTE 4'h8
`define TPL_WRITE_LEN 4'h9
`define TPL_CRC_LEN 4'h3
`define TPL_PKT_STEP 9'h008
`endif

// ==== shared/tpl_pkg.sv ====
package tpl_pkg;
  // Serial-side phase of the current transaction
  typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_RX, BUS_TX} tpl_bus_t;
  // Background profile engine
  typedef enum logic [1:0] {ENG_IDLE, ENG_ERASE, ENG_SCAN, ENG_CHECK} tpl_eng_t;
endpackage

// ==== shared/tpl_crc_if.sv ====
interface tpl_crc_if;
  logic clear;
  logic feed;
  logic [7:0] data_byte;
  logic [15:0] crc;
  modport engine (output clear, output feed, output data_byte, input crc);
  modport unit (input clear, input feed, input data_byte, output crc);
endinterface

// ==== verilog/tpl_crc_unit.sv ====
`include "tpl_defs.svh"
module tpl_crc_unit import tpl_pkg::*; (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  tpl_crc_if.unit crc_port
);
  // One whole byte per clock; unrolled bit loop keeps the scan at one cycle per byte
  function automatic logic [15:0] tpl_crc_step(input logic [15:0] acc, input logic [7:0] din);
    logic [15:0] r;
    r = acc ^ {din, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ({r[14:0], 1'b0} ^ `TPL_CRC_POLY) : {r[14:0], 1'b0};
    end
    return r;
  endfunction

  logic [15:0] acc;
  wire logic [15:0] next_acc = tpl_crc_step(acc, crc_port.data_byte);

  // Clear wins over feed so a new scan always starts from the seed
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || crc_port.clear) begin
      acc <= `TPL_CRC_SEED;
    end else if (crc_port.feed) begin
      acc <= next_acc;
    end
  end

  assign crc_port.crc = acc;
endmodule // tpl_crc_unit

// ==== test/tpl_sva.sv ====
module tpl_sva (
  input wire logic i_sys_clk,
  input wire logic i_reset,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic i_int_n,
  input wire logic o_sensing_mode,
  input wire logic o_profile_valid,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  // Length of the running busy stretch; saturates so it never wraps
  logic [10:0] busy_len;
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || !o_busy) busy_len <= 11'h000;
    else if (busy_len != 11'h7ff) busy_len <= busy_len + 11'h001;
  end
  // Sensing mode is left only by reset
  property p_sense_hold; o_sensing_mode |=> o_sensing_mode; endproperty
  a_sense_hold: assert property (p_sense_hold) else $error("sensing mode dropped");
  property p_sense_quiet; o_sensing_mode |-> !o_sda_oe; endproperty
  a_sense_quiet: assert property (p_sense_quiet) else $error("bus driven in sensing");
  property p_sense_valid; $rose(o_sensing_mode) |-> $past(o_profile_valid) && !$past(o_busy);
  endproperty
  a_sense_valid: assert property (p_sense_valid) else $error("sensing without profile");
  property p_valid_check; $rose(o_profile_valid) |-> $past(o_busy) || $past(o_busy, 2);
  endproperty
  a_valid_check: assert property (p_valid_check) else $error("valid outside check");
  property p_valid_clear; $fell(o_profile_valid) |-> ##[0:2] o_busy; endproperty
  a_valid_clear: assert property (p_valid_clear) else $error("valid lost while idle");
  // A full scan covers 510 bytes, so busy cannot end sooner
  property p_scan_len; $fell(o_busy) |-> busy_len >= 11'h1fd; endproperty
  a_scan_len: assert property (p_scan_len) else $error("scan too short");
  property p_sda_move; $changed(o_sda_oe) |-> !i_scl; endproperty
  a_sda_move: assert property (p_sda_move) else $error("sda moved with scl high");
  property p_cs_drive; $rose(o_sda_oe) |-> !$past(i_int_n, 2); endproperty
  a_cs_drive: assert property (p_cs_drive) else $error("drive without select");
endmodule // tpl_sva

// ==== test/tpl_host.sv ====
module tpl_host (
  input wire logic i_sys_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low,
  output logic o_int_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle, line released
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    o_int_n = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  // One bit slot; SDA moves only with SCL low, half periods of 8 cycles
  task automatic bit_slot(input logic b, output logic seen);
    wt(2);
    o_sda_low = !b;
    wt(6);
    o_scl = 1'b1;
    wt(8);
    seen = i_sda;
    o_scl = 1'b0;
  endtask
  // Write bytes, then read nrd bytes; a refused byte ends the transfer
  task automatic xfer(input logic [7:0] d [$], input logic cs, input int nrd,
                      output logic ok, output logic [15:0] v);
    logic s;
    v = 16'h0000;
    ok = 1'b1;
    o_int_n = !cs;
    wt(4);
    o_sda_low = 1'b1;
    wt(8);
    o_scl = 1'b0;
    foreach (d[k]) begin
      if (ok) begin
        for (int b = 7; b >= 0; b--) bit_slot(d[k][b], s);
        bit_slot(1'b1, s);
        ok = !s;
      end
    end
    for (int r = 0; r < nrd; r++) begin
      if (ok) begin
        for (int b = 7; b >= 0; b--) begin
          bit_slot(1'b1, s);
          v = {v[14:0], s};
        end
        bit_slot(r == nrd - 1, s);
      end
    end
    wt(2);
    o_sda_low = 1'b1;
    wt(6);
    o_scl = 1'b1;
    wt(8);
    o_sda_low = 1'b0;
    wt(8);
    o_int_n = 1'b1;
    // Select stays high a while, so a resend never lowers it in the same step
    wt(4);
  endtask
endmodule // tpl_host

// ==== test/touch_profile_loader_crc_bench.sv ====
`include "tpl_defs.svh"
module touch_profile_loader_crc_bench import tpl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_sys_clk;
  logic i_reset;
  logic scl, sda_low, int_n, sda, dut_sda, dut_oe, sensing, valid, busy, ok;
  logic [15:0] rv;
  logic [15:0] crc;
  logic [7:0] img [510];
  int n_mismatch;
  int cmp_count;
`define TPL_CHECK(name, exp, got) begin cmp_count++; if ((got) !== (exp)) begin \
  n_mismatch++; $display("wrong value %s exp %0h got %0h", name, exp, got); end end
  // Open-drain data line with pull-up
  assign sda = !(sda_low || (dut_oe && !dut_sda));
  tpl_loader i_dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_scl(scl), .i_sda(sda),
    .o_sda(dut_sda), .o_sda_oe(dut_oe), .i_int_n(int_n), .o_sensing_mode(sensing),
    .o_profile_valid(valid), .o_busy(busy));
  tpl_host i_host (.i_sys_clk(i_sys_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low),
    .o_int_n(int_n));
  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Command byte as one element; a bare nibble in a queue literal would become a byte of its own
  function automatic logic [7:0] cmd_byte(input logic [3:0] hi, input logic [3:0] c);
    return {hi, c};
  endfunction
  // Bench-side CRC over the whole padded image
  function automatic logic [15:0] crc_img();
    logic [15:0] c;
    c = 16'hffff;
    for (int a = 0; a < 510; a++) begin
      c = c ^ {img[a], 8'h00};
      for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ 16'h1021) : (c << 1);
    end
    return c;
  endfunction
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    if (busy !== 1'b0) begin
      n_mismatch++;
      give_verdict();
    end
  endtask
  // Resend until taken; the device refuses packets while it works
  task automatic send(input logic [7:0] d [$]);
    int n;
    n = 0;
    ok = 1'b0;
    while (!ok && n < 40) begin
      i_host.xfer(d, 1'b1, 0, ok, rv);
      n++;
    end
    `TPL_CHECK("packet ack", 1'b1, ok)
  endtask
  task automatic chk_stat(input logic [7:0] exp);
    i_host.xfer({8'hc1}, 1'b1, 2, ok, rv);
    `TPL_CHECK("read address ack", 1'b1, ok)
    `TPL_CHECK("status bytes", {exp, exp}, rv)
  endtask
  task automatic t_startup();
    chk_stat(`TPL_STAT_INVALID);
    wait_idle();
    `TPL_CHECK("valid after wipe", 1'b0, valid)
    send({8'hc0, cmd_byte(4'h0, `TPL_CMD_MODE)});
    `TPL_CHECK("mode while invalid", 1'b0, sensing)
  endtask
  // Deselected or foreign address must get no answer
  task automatic t_select();
    i_host.xfer({8'hc0, 8'h09}, 1'b0, 0, ok, rv);
    `TPL_CHECK("ack with select high", 1'b0, ok)
    i_host.xfer({8'hc2}, 1'b1, 0, ok, rv);
    `TPL_CHECK("ack of other address", 1'b0, ok)
  endtask
  task automatic t_busy();
    send({8'hc0, cmd_byte(4'h0, `TPL_CMD_UNLOCK)});
    send({8'hc0, cmd_byte(4'h0, `TPL_CMD_ERASE)});
    i_host.xfer({8'hc0, cmd_byte(4'h0, `TPL_CMD_WRITE)}, 1'b1, 0, ok, rv);
    `TPL_CHECK("write taken while busy", 1'b0, ok)
    wait_idle();
  endtask
  // Two packets then the checksum of the padded image; a wrong checksum first
  task automatic t_load();
    logic [7:0] q [$];
    foreach (img[a]) img[a] = (a < 16) ? 8'(a * 37 + 5) : 8'hff;
    crc = crc_img();
    for (int p = 0; p < 2; p++) begin
      q = {8'hc0, cmd_byte(4'h2, `TPL_CMD_WRITE)};
      for (int i = 0; i < 8; i++) q.push_back(img[8 * p + i]);
      send(q);
    end
    send({8'hc0, cmd_byte(4'h0, `TPL_CMD_CRC), crc[15:8], ~crc[7:0]});
    wait_idle();
    `TPL_CHECK("valid with bad checksum", 1'b0, valid)
    send({8'hc0, cmd_byte(4'h0, `TPL_CMD_CRC), crc[15:8], crc[7:0]});
    wait_idle();
    `TPL_CHECK("valid with good checksum", 1'b1, valid)
    chk_stat(`TPL_STAT_VALID);
  endtask
  task automatic t_mode();
    send({8'hc0, cmd_byte(4'h0, `TPL_CMD_MODE)});
    `TPL_CHECK("sensing entered", 1'b1, sensing)
    i_host.xfer({8'hc1}, 1'b1, 1, ok, rv);
    `TPL_CHECK("loader silent in sensing", 1'b0, ok)
  endtask
  initial begin
    n_mismatch = 0;
    cmp_count = 0;
    i_reset = 1'b1;
    repeat (4) @(posedge i_sys_clk);
    #1;
    `TPL_CHECK("busy in reset", 1'b1, busy)
    `TPL_CHECK("sensing in reset", 1'b0, sensing)
    i_reset = 1'b0;
    t_startup();
    t_select();
    t_busy();
    t_load();
    t_mode();
    give_verdict();
  end
endmodule // touch_profile_loader_crc_bench
bind tpl_loader tpl_sva i_sva (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_scl(i_scl),
  .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_int_n(i_int_n),
  .o_sensing_mode(o_sensing_mode), .o_profile_valid(o_profile_valid), .o_busy(o_busy));
